// *** hdl/cirq_chan.sv ***
`include "cirq_consts.svh"

module cirq_chan
	import cirq_pkg::*;
#(
	parameter int STORE_REGS = `CIRQ_STORE_REGS
)(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic rd_sel,
	input wire logic wr_sel,
	input wire logic [3:0] sub,
	input wire logic [7:0] wdata,
	input wire logic [3:0] src_event,
	input wire logic [3:0] alarm_state,
	output logic [7:0] rdata,
	output logic pending
);
	// ==================================================================
	// decode
	logic [3:0] source_interrupt_enable;
	logic [3:0] src_status;
	cirq_byte_t store [STORE_REGS];
	wire store_a = sub >= `CIRQ_SUB_STORE_A_FIRST &&
		sub <= `CIRQ_SUB_STORE_A_LAST;
	wire store_b = sub >= `CIRQ_SUB_STORE_B_FIRST &&
		sub <= `CIRQ_SUB_STORE_B_LAST;
	wire store_hit = store_a || store_b;
	wire [3:0] store_off = store_b ? sub - `CIRQ_SUB_STORE_B_BASE :
		sub - `CIRQ_SUB_STORE_A_FIRST;
	wire [2:0] store_idx = store_off[2:0];
	wire status_rd = rd_sel && sub == `CIRQ_SUB_SRC_STATUS;
	wire enable_wr = wr_sel && sub == `CIRQ_SUB_SRC_ENABLE;
	// a new event in the clearing read cycle survives the clear
	wire [3:0] next_src_status = (src_event & source_interrupt_enable) |
		(status_rd ? `CIRQ_RESET_NIBBLE : src_status); // see R4

	assign rdata = sub == `CIRQ_SUB_SRC_ENABLE ?
		{4'h0, source_interrupt_enable} :
		sub == `CIRQ_SUB_SRC_STATUS ? {4'h0, src_status} :
		sub == `CIRQ_SUB_ALARM_STATE ? {4'h0, alarm_state} :
		store_hit ? store[store_idx] : `CIRQ_RESET_BYTE; // see R8
	assign pending = |src_status; // see R2

	// ==================================================================
	// storage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			source_interrupt_enable <= `CIRQ_RESET_NIBBLE;
			src_status <= `CIRQ_RESET_NIBBLE;
		end else begin
			if (enable_wr)
				source_interrupt_enable <= wdata[3:0];
			src_status <= next_src_status;
		end
	end

	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < STORE_REGS; i++) begin
			if (rst)
				store[i] <= `CIRQ_RESET_BYTE;
			else if (wr_sel && store_hit && store_idx == 3'(i))
				store[i] <= wdata; // see R8
		end
	end

	// ==================================================================
	// assertions
	a_event_sets_flag: assert property (@(posedge ref_clk) // see R2
		disable iff (rst)
		(src_event & source_interrupt_enable) != 4'h0 |=> pending)
		else $error("enabled source event did not raise the flag");

	a_quiet_flag_stays: assert property (@(posedge ref_clk) // see R2
		disable iff (rst)
		!pending && (src_event & source_interrupt_enable) == 4'h0 |=>
			!pending)
		else $error("flag rose with no enabled source event");
endmodule // cirq_chan

// *** hdl/cirq_consts.svh ***
`ifndef CIRQ_CONSTS_SVH
`define CIRQ_CONSTS_SVH

// ==========================================================================
// global register addresses
`define CIRQ_LO_MASTER_ENABLE 8'h60
`define CIRQ_LO_PENDING_STATUS 8'h61
`define CIRQ_PART_IDENTIFICATION 8'h6e
`define CIRQ_SILICON_REVISION 8'h6f
`define CIRQ_UP_MASTER_ENABLE 8'he0
`define CIRQ_UP_PENDING_STATUS 8'he1

// ==========================================================================
// address page numbers (upper nibble)
`define CIRQ_PAGE_LO_FIRST 4'h0
`define CIRQ_PAGE_LO_LAST 4'h5
`define CIRQ_PAGE_UP_FIRST 4'h8
`define CIRQ_PAGE_UP_LAST 4'hd
`define CIRQ_PAGE_UP_SHIFT 4'h2

// ==========================================================================
// per-channel register offsets (lower nibble)
`define CIRQ_SUB_SRC_ENABLE 4'h1
`define CIRQ_SUB_SRC_STATUS 4'h2
`define CIRQ_SUB_ALARM_STATE 4'h3
`define CIRQ_SUB_STORE_A_FIRST 4'h4
`define CIRQ_SUB_STORE_A_LAST 4'h7
`define CIRQ_SUB_STORE_B_FIRST 4'ha
`define CIRQ_SUB_STORE_B_LAST 4'hc
`define CIRQ_SUB_STORE_B_BASE 4'h6

// ==========================================================================
// sizes and reset values
`define CIRQ_CHANNELS 12
`define CIRQ_HALF 6
`define CIRQ_SOURCES 4
`define CIRQ_STORE_REGS 7
`define CIRQ_RESET_BYTE 8'h00
`define CIRQ_RESET_NIBBLE 4'h0

`endif

// *** hdl/cirq_pkg.sv ***
package cirq_pkg;
	// one access on the parallel register port
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cirq_req_s;
	typedef logic [7:0] cirq_byte_t;
endpackage

// *** hdl/cirq_top.sv ***
// Overview of operation
// R1 - channels 11..6 flags in bits 5..0
// R2 - flag one while channel interrupt awaits service
// R3 - lower six channels in companion status register
// R4 - flag holds until channel source status read
// R5 - host reads source status after seeing flag
// R6 - fixed read-only part identification byte
// R7 - revision upper nibble zero, lower nibble digit
// R8 - ten registers replicated for twelve channels
// R9 - cleared master enable blocks channel interrupt
// R10 - status and identity reads have no side effects
`include "cirq_consts.svh"

module cirq_top
	import cirq_pkg::*;
#(
	// arbitrary neutral identity values
	parameter logic [7:0] PART_ID = 8'h5a,
	parameter logic [3:0] REV_DIGIT = 4'h3,
	parameter int CHANNELS = `CIRQ_CHANNELS
)(
	input wire logic ref_clk,
	input wire logic rst,
	input wire cirq_req_s cpu,
	input wire logic [CHANNELS*4-1:0] src_event,
	input wire logic [CHANNELS*4-1:0] alarm_state,
	output cirq_byte_t cpu_rdata,
	output logic int_req
);
	// ==================================================================
	// address decode
	wire [3:0] page = cpu.addr[7:4];
	wire [3:0] sub = cpu.addr[3:0];
	wire lo_page = page <= `CIRQ_PAGE_LO_LAST;
	wire up_page = page >= `CIRQ_PAGE_UP_FIRST &&
		page <= `CIRQ_PAGE_UP_LAST;
	wire chan_hit = lo_page || up_page;
	wire [3:0] chan_idx = up_page ? page - `CIRQ_PAGE_UP_SHIFT : page;
	wire hit_lo_en = cpu.addr == `CIRQ_LO_MASTER_ENABLE;
	wire hit_up_en = cpu.addr == `CIRQ_UP_MASTER_ENABLE;
	wire hit_lo_st = cpu.addr == `CIRQ_LO_PENDING_STATUS;
	wire hit_up_st = cpu.addr == `CIRQ_UP_PENDING_STATUS;
	wire hit_part = cpu.addr == `CIRQ_PART_IDENTIFICATION;
	wire hit_rev = cpu.addr == `CIRQ_SILICON_REVISION;

	// ==================================================================
	// per-channel banks
	logic [CHANNELS-1:0] pending;
	logic [CHANNELS-1:0][7:0] chan_rdata;
	logic [CHANNELS-1:0] master_enable;

	for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
		wire sel = chan_hit && chan_idx == 4'(g);
		cirq_chan u_chan (
			.ref_clk(ref_clk),
			.rst(rst),
			.rd_sel(cpu.rd && sel),
			.wr_sel(cpu.wr && sel),
			.sub(sub),
			.wdata(cpu.wdata),
			.src_event(src_event[g*4 +: 4]),
			.alarm_state(alarm_state[g*4 +: 4]),
			.rdata(chan_rdata[g]),
			.pending(pending[g])
		); // see R8
	end

	// ==================================================================
	// read mux
	wire [7:0] lo_status = {2'b00, pending[`CIRQ_HALF-1:0]}; // see R3
	wire [7:0] up_status = {2'b00, pending[CHANNELS-1:`CIRQ_HALF]}; // see R1
	wire [7:0] lo_enable = {2'b00, master_enable[`CIRQ_HALF-1:0]};
	wire [7:0] up_enable = {2'b00, master_enable[CHANNELS-1:`CIRQ_HALF]};
	wire [7:0] next_cpu_rdata = hit_up_st ? up_status :
		hit_lo_st ? lo_status :
		hit_part ? PART_ID : // see R6
		hit_rev ? {4'h0, REV_DIGIT} : // see R7
		hit_up_en ? up_enable :
		hit_lo_en ? lo_enable :
		chan_hit ? chan_rdata[chan_idx] : `CIRQ_RESET_BYTE;

	// ==================================================================
	// registers
	// read data is held until the next read so the host may sample late
	always_ff @(posedge ref_clk) begin
		if (rst)
			cpu_rdata <= `CIRQ_RESET_BYTE;
		else if (cpu.rd)
			cpu_rdata <= next_cpu_rdata; // see R10
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			master_enable <= '0;
		else if (cpu.wr && hit_lo_en)
			master_enable[`CIRQ_HALF-1:0] <= cpu.wdata[`CIRQ_HALF-1:0];
		else if (cpu.wr && hit_up_en)
			master_enable[CHANNELS-1:`CIRQ_HALF] <=
				cpu.wdata[`CIRQ_HALF-1:0];
	end

	// combinational so a flag reaches the pin without a cycle of lag
	assign int_req = |(pending & master_enable); // see R9

	// ==================================================================
	// assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	wire isr6_rd = cpu.rd && cpu.addr == 8'h82;
	wire isr11_rd = cpu.rd && cpu.addr == 8'hd2;
	wire status_rd = cpu.rd && (hit_lo_st || hit_up_st || hit_part ||
		hit_rev);
	wire src_rd = cpu.rd && chan_hit && sub == `CIRQ_SUB_SRC_STATUS;
	// flags that are allowed to reach the request pin
	wire [CHANNELS-1:0] live = pending & master_enable;

	a_upper_status_map: assert property ( // see R1
		cpu.rd && hit_up_st |=>
			cpu_rdata == {2'b00, $past(pending[11:6])})
		else $error("upper status read mismatch");

	a_upper_reserved: assert property ( // see R1
		cpu.rd && hit_up_st |=> cpu_rdata[7:6] == 2'b00)
		else $error("upper status reserved bits set");

	a_flag_meaning: assert property ( // see R2
		cpu.rd && hit_up_st && pending[7] |=> cpu_rdata[1])
		else $error("set flag read back as zero");

	a_idle_flag_zero: assert property ( // see R2
		cpu.rd && hit_up_st && !pending[7] |=> !cpu_rdata[1])
		else $error("clear flag read back as one");

	a_lower_status_map: assert property ( // see R3
		cpu.rd && hit_lo_st |=>
			cpu_rdata == {2'b00, $past(pending[5:0])})
		else $error("lower status read mismatch");

	a_lower_reserved: assert property ( // see R3
		cpu.rd && hit_lo_st |=> cpu_rdata[7:6] == 2'b00)
		else $error("lower status reserved bits set");

	a_flag_held_ch6: assert property ( // see R4
		$fell(pending[6]) |-> $past(isr6_rd))
		else $error("channel 6 flag dropped without source read");

	a_flag_held_ch11: assert property ( // see R4
		pending[11] && !isr11_rd |=> pending[11])
		else $error("channel 11 flag dropped without source read");

	// the same hold rule for every channel
	for (genvar h = 0; h < CHANNELS; h++) begin : g_hold
		a_flag_hold: assert property ( // see R4
			pending[h] && !(src_rd && chan_idx == 4'(h)) |=>
				pending[h])
			else $error("channel flag dropped without source read");
	end

	a_part_id_fixed: assert property ( // see R6
		cpu.rd && hit_part |=> cpu_rdata == PART_ID)
		else $error("part identification value wrong");

	a_part_id_stays: assert property ( // see R6
		cpu.wr && hit_part ##2 cpu.rd && hit_part |=>
			cpu_rdata == PART_ID)
		else $error("part identification changed by a write");

	a_revision_form: assert property ( // see R7
		cpu.rd && hit_rev |=>
			cpu_rdata[7:4] == 4'h0 && cpu_rdata[3:0] == REV_DIGIT)
		else $error("revision register format wrong");

	a_chan_reg_rw: assert property ( // see R8
		cpu.wr && cpu.addr == 8'hd4 && !cpu.rd ##1 !cpu.wr ##1
		cpu.rd && !cpu.wr && cpu.addr == 8'hd4 |=>
			cpu_rdata == $past(cpu.wdata, 3))
		else $error("per-channel register readback wrong");

	a_alarm_readback: assert property ( // see R8
		cpu.rd && !cpu.wr && cpu.addr == 8'hd3 |=>
			cpu_rdata == {4'h0, $past(alarm_state[47:44])})
		else $error("alarm state readback wrong");

	a_unmapped_zero: assert property ( // see R8
		cpu.rd && cpu.addr == 8'h7f |=> cpu_rdata == 8'h00)
		else $error("unmapped address read as nonzero");

	a_master_gate: assert property ( // see R9
		master_enable == '0 |-> !int_req)
		else $error("interrupt raised while all channels disabled");

	a_int_only_enabled: assert property ( // see R9
		int_req |-> live != '0)
		else $error("interrupt raised by a masked channel");

	a_int_when_live: assert property ( // see R9
		live != '0 |-> int_req)
		else $error("enabled pending channel gave no interrupt");

	a_upper_enable_wr: assert property ( // see R9
		cpu.wr && hit_up_en |=>
			master_enable[11:6] == $past(cpu.wdata[5:0]))
		else $error("upper master enable write lost");

	a_lower_enable_wr: assert property ( // see R9
		cpu.wr && hit_lo_en |=>
			master_enable[5:0] == $past(cpu.wdata[5:0]))
		else $error("lower master enable write lost");

	a_read_no_side: assert property ( // see R10
		status_rd && !cpu.wr && src_event == '0 |=>
			pending == $past(pending))
		else $error("status read disturbed flags");

	a_rdata_hold: assert property ( // see R10
		!cpu.rd |=> $stable(cpu_rdata))
		else $error("read data changed without a read");

	c_flag_rise: cover property ($rose(pending[6]));
	c_int_rise: cover property ($rose(int_req));
	c_flag_clear: cover property (pending[11] && isr11_rd ##1 !pending[11]);
	c_status_seen: cover property (cpu.rd && hit_up_st && pending[11:6] != 0);
	c_masked_flag: cover property (pending[7] && !master_enable[7]);
endmodule // cirq_top

// *** test/cirq_host.sv ***
module cirq_host
	import cirq_pkg::*;
(
	input wire logic ref_clk,
	input wire cirq_byte_t cpu_rdata,
	output cirq_req_s cpu
);
	timeunit 1ns;
	timeprecision 1ns;
	// ========================================
	// host side of the register port
	initial cpu = '0;
	// released address and data lines show the inverse, so a stale value never passes
	task automatic xfer(input logic w, input logic [7:0] a,
		input cirq_byte_t d, output cirq_byte_t q);
		@(negedge ref_clk);
		cpu = '{rd: !w, wr: w, addr: a, wdata: d};
		@(negedge ref_clk);
		q = cpu_rdata;
		cpu = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule // cirq_host

// *** test/cirq_top_tb_top.sv ***
`include "cirq_consts.svh"

module cirq_top_tb_top
	import cirq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// arbitrary identity values
	localparam logic [7:0] PID = 8'h5a;
	localparam logic [3:0] RDIG = 4'h3;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	cirq_req_s cpu;
	logic [47:0] src_event = '0;
	logic [47:0] alarm_state = '0;
	cirq_byte_t cpu_rdata;
	cirq_byte_t q;
	logic int_req;
	int bad_count = 0;
	int compares = 0;
	initial forever #25 ref_clk = ~ref_clk;
	cirq_top #(.PART_ID(PID), .REV_DIGIT(RDIG), .CHANNELS(12)) DUT (
		.ref_clk(ref_clk), .rst(rst), .cpu(cpu), .src_event(src_event),
		.alarm_state(alarm_state), .cpu_rdata(cpu_rdata), .int_req(int_req));
	cirq_host host (.ref_clk(ref_clk), .cpu_rdata(cpu_rdata), .cpu(cpu));
	// ========================================
	// helpers
	task automatic check(input cirq_byte_t seen, input cirq_byte_t exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input cirq_byte_t exp);
		host.xfer(1'b0, a, 8'h00, q);
		check(q, exp);
	endtask
	task automatic wr(input logic [7:0] a, input cirq_byte_t d);
		host.xfer(1'b1, a, d, q);
	endtask
	function automatic logic [7:0] page(input int ch);
		return 8'((ch < 6 ? ch : ch + 2) * 16);
	endfunction
	task automatic pulse(input int ch, input logic [3:0] s);
		@(negedge ref_clk);
		src_event[ch*4 +: 4] = s;
		@(negedge ref_clk);
		src_event = '0;
	endtask
	task automatic conclude;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ========================================
	// scenarios
	task automatic ident_regs;
		rd(`CIRQ_PART_IDENTIFICATION, PID);
		wr(`CIRQ_PART_IDENTIFICATION, ~PID);
		rd(`CIRQ_PART_IDENTIFICATION, PID);
		rd(`CIRQ_SILICON_REVISION, {4'h0, RDIG});
		rd(8'h7f, 8'h00);
	endtask
	task automatic channel_flags;
		int ch;
		logic [7:0] st;
		cirq_byte_t bv;
		wr(`CIRQ_UP_MASTER_ENABLE, 8'h3f);
		wr(`CIRQ_LO_MASTER_ENABLE, 8'h3f);
		for (ch = 0; ch < 12; ch++) begin
			st = ch < 6 ? `CIRQ_LO_PENDING_STATUS : `CIRQ_UP_PENDING_STATUS;
			bv = 8'h01 << (ch % 6);
			wr(page(ch) | 8'h01, 8'h04);
			pulse(ch, 4'h4);
			check({7'h00, int_req}, 8'h01);
			rd(st, bv);
			rd(st, bv);
			rd(st ^ 8'h80, 8'h00);
			// the service routine learns the cause from source status
			rd(page(ch) | 8'h02, 8'h04);
			rd(st, 8'h00);
			check({7'h00, int_req}, 8'h00);
			wr(page(ch) | 8'h01, 8'h00);
		end
	endtask
	task automatic masking;
		wr(`CIRQ_UP_MASTER_ENABLE, 8'h3d);
		wr(page(7) | 8'h01, 8'h03);
		pulse(7, 4'h8);
		rd(`CIRQ_UP_PENDING_STATUS, 8'h00);
		pulse(7, 4'h2);
		check({7'h00, int_req}, 8'h00);
		rd(`CIRQ_UP_PENDING_STATUS, 8'h02);
		wr(`CIRQ_UP_MASTER_ENABLE, 8'h3f);
		check({7'h00, int_req}, 8'h01);
		rd(page(7) | 8'h02, 8'h02);
		check({7'h00, int_req}, 8'h00);
	endtask
	task automatic storage;
		int ch;
		alarm_state = 48'hba9876543210;
		for (ch = 0; ch < 12; ch++) begin
			wr(page(ch) | 8'h04, 8'(ch * 17));
			rd(page(ch) | 8'h04, 8'(ch * 17));
			wr(page(ch) | 8'h0c, 8'(~ch));
		end
		for (ch = 0; ch < 12; ch++) begin
			rd(page(ch) | 8'h04, 8'(ch * 17));
			rd(page(ch) | 8'h0c, 8'(~ch));
			host.xfer(1'b0, page(ch) | 8'h03, 8'h00, q);
			check(q & 8'h0f, 8'(ch));
		end
	endtask
	// ========================================
	// main sequence and hang guard
	initial begin
		repeat (20) @(negedge ref_clk);
		rst = 1'b0;
		check(cpu_rdata, 8'h00);
		check({7'h00, int_req}, 8'h00);
		ident_regs;
		channel_flags;
		masking;
		storage;
		conclude;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		conclude;
	end
endmodule // cirq_top_tb_top
